// ---- common/pafo_pkg.sv ----
package pafo_pkg;
  localparam int PAFO_W = 8;
  // register byte offsets on the apb bus
  localparam logic [7:0] PAFO_OFF_DIR = 8'h00;
  localparam logic [7:0] PAFO_OFF_LATCH = 8'h04;
  localparam logic [7:0] PAFO_OFF_PIN = 8'h08;
  localparam logic [7:0] PAFO_OFF_CTRL = 8'h0C;
  localparam logic [7:0] PAFO_OFF_MASK = 8'h10;
  localparam logic [7:0] PAFO_OFF_ADCOFF = 8'h14;
  // control register fields
  localparam int PAFO_CTRL_GPO_BIT = 0;
  localparam int PAFO_CTRL_PIN_CHANGE_GROUP0_ENABLE_BIT = 1;
  // reset values
  localparam logic [7:0] PAFO_RST_DIR = 8'h00;
  localparam logic [7:0] PAFO_RST_LATCH = 8'h00;
  localparam logic [7:0] PAFO_RST_MASK = 8'h00;
  localparam logic [7:0] PAFO_RST_ADCOFF = 8'h00;
  localparam logic [7:0] PAFO_RST_PAD = 8'h00;
  localparam logic [7:0] PAFO_RST_IN_EN = 8'h00;
  localparam logic PAFO_RST_GPO = 1'b0;
  localparam logic PAFO_RST_PIN_CHANGE_GROUP0_ENABLE = 1'b0;
  localparam logic [31:0] PAFO_RST_WORD = 32'h0000_0000;
  typedef logic [7:0] pafo_byte_t;
endpackage

// ---- common/pafo_pin_if.sv ----
`timescale 1ns/1ps
interface pafo_pin_if;
  logic direction_bit;
  logic output_latch_bit;
  logic global_pullup_off;
  logic sleep_clamp;
  logic pull_up_override_enable;
  logic pull_up_override_value;
  logic drive_override_enable;
  logic drive_override_value;
  logic pin_value_override_enable;
  logic pin_value_override_value;
  logic input_enable_override_enable;
  logic input_enable_override_value;
  logic pull_en;
  logic drv_en;
  logic drv_val;
  logic in_en;
  modport ctl (
    output direction_bit, output_latch_bit, global_pullup_off, sleep_clamp,
    output pull_up_override_enable, pull_up_override_value,
    output drive_override_enable, drive_override_value,
    output pin_value_override_enable, pin_value_override_value,
    output input_enable_override_enable, input_enable_override_value,
    input pull_en, drv_en, drv_val, in_en
  );
  modport mux (
    input direction_bit, output_latch_bit, global_pullup_off, sleep_clamp,
    input pull_up_override_enable, pull_up_override_value,
    input drive_override_enable, drive_override_value,
    input pin_value_override_enable, pin_value_override_value,
    input input_enable_override_enable, input_enable_override_value,
    output pull_en, drv_en, drv_val, in_en
  );
endinterface

// ---- src/pafo_pin_mux.sv ----
`timescale 1ns/1ps
// one pin's override selection, purely combinational
module pafo_pin_mux (
  pafo_pin_if.mux p
);
  always_comb begin
    if (p.pull_up_override_enable) begin
      p.pull_en = p.pull_up_override_value;
    end else begin
      p.pull_en = ~p.direction_bit & p.output_latch_bit & ~p.global_pullup_off;
    end
    if (p.drive_override_enable) begin
      p.drv_en = p.drive_override_value;
    end else begin
      p.drv_en = p.direction_bit;
    end
    if (!p.drv_en) begin
      p.drv_val = 1'b0;
    end else if (p.pin_value_override_enable) begin
      p.drv_val = p.pin_value_override_value;
    end else begin
      p.drv_val = p.output_latch_bit;
    end
    if (p.input_enable_override_enable) begin
      p.in_en = p.input_enable_override_value;
    end else begin
      p.in_en = ~p.sleep_clamp;
    end
  end
endmodule

// ---- src/pafo_port.sv ----
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module pafo_port
  import pafo_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PAFO_W-1:0] pad_in,
  output logic [PAFO_W-1:0] pad_out,
  output logic [PAFO_W-1:0] pad_oe,
  output logic [PAFO_W-1:0] pad_pullup_en,
  output logic [PAFO_W-1:0] schmitt_input_tap,
  input wire logic sleep_clamp,
  input wire logic [PAFO_W-1:0] toggle_override_enable
);

  typedef struct packed {
    pafo_byte_t dir;
    pafo_byte_t latch;
    pafo_byte_t mask;
    pafo_byte_t adc_off;
    logic gpo;
    logic pin_change_group0_enable;
    pafo_byte_t sync1;
    pafo_byte_t sync2;
    pafo_byte_t in_en;
    pafo_byte_t oe;
    pafo_byte_t out;
    pafo_byte_t pull;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pafo_state_s;

  pafo_state_s s_reg;
  pafo_state_s s_next;

  logic [PAFO_W-1:0] mux_pull;
  logic [PAFO_W-1:0] mux_drv_en;
  logic [PAFO_W-1:0] mux_drv_val;
  logic [PAFO_W-1:0] mux_in_en;
  logic [PAFO_W-1:0] input_enable_override_enable_v;
  logic [PAFO_W-1:0] input_enable_override_value_v;
  logic acc_first;
  logic commit_wr;
  logic [PAFO_W-1:0] pin_toggle;

  // pin-change / analog mapping of this port, all eight pins alike
  assign input_enable_override_value_v = s_reg.mask & {PAFO_W{s_reg.pin_change_group0_enable}};
  assign input_enable_override_enable_v = input_enable_override_value_v | s_reg.adc_off;

  generate
    for (genvar i = 0; i < PAFO_W; i++) begin : g_pin
      pafo_pin_if pin_if ();
      assign pin_if.direction_bit = s_reg.dir[i];
      assign pin_if.output_latch_bit = s_reg.latch[i];
      assign pin_if.global_pullup_off = s_reg.gpo;
      assign pin_if.sleep_clamp = sleep_clamp;
      // no peripheral here drives pull-up, drive or pin-value overrides
      assign pin_if.pull_up_override_enable = 1'b0;
      assign pin_if.pull_up_override_value = 1'b0;
      assign pin_if.drive_override_enable = 1'b0;
      assign pin_if.drive_override_value = 1'b0;
      assign pin_if.pin_value_override_enable = 1'b0;
      assign pin_if.pin_value_override_value = 1'b0;
      assign pin_if.input_enable_override_enable = input_enable_override_enable_v[i];
      assign pin_if.input_enable_override_value = input_enable_override_value_v[i];
      assign mux_pull[i] = pin_if.pull_en;
      assign mux_drv_en[i] = pin_if.drv_en;
      assign mux_drv_val[i] = pin_if.drv_val;
      assign mux_in_en[i] = pin_if.in_en;
      pafo_pin_mux u_mux (
        .p(pin_if.mux)
      );
    end
  endgenerate

  // tap after the input gate, ahead of the port synchroniser
  assign schmitt_input_tap = pad_in & s_reg.in_en;

  // first apb access cycle answers next cycle; write lands with pready
  assign acc_first = psel & penable & ~s_reg.pready;
  assign commit_wr = psel & penable & s_reg.pready & pwrite;

  always_comb begin
    pin_toggle = toggle_override_enable;
    if (commit_wr && paddr == PAFO_OFF_PIN) begin
      pin_toggle = pin_toggle | pwdata[7:0];
    end
  end

  always_comb begin
    s_next = s_reg;
    // clamp before the synchroniser, like the schmitt input gate
    s_next.sync1 = pad_in & s_reg.in_en;
    s_next.sync2 = s_reg.sync1;
    s_next.in_en = mux_in_en;
    s_next.oe = mux_drv_en;
    s_next.out = mux_drv_val;
    s_next.pull = mux_pull;
    s_next.pready = acc_first;
    s_next.pslverr = 1'b0;
    s_next.prdata = PAFO_RST_WORD;
    if (acc_first) begin
      unique case (paddr)
        PAFO_OFF_DIR: s_next.prdata = {24'h00_0000, s_reg.dir};
        PAFO_OFF_LATCH: s_next.prdata = {24'h00_0000, s_reg.latch};
        PAFO_OFF_PIN: s_next.prdata = {24'h00_0000, s_reg.sync2};
        PAFO_OFF_CTRL: s_next.prdata = {30'h0000_0000, s_reg.pin_change_group0_enable, s_reg.gpo};
        PAFO_OFF_MASK: s_next.prdata = {24'h00_0000, s_reg.mask};
        PAFO_OFF_ADCOFF: s_next.prdata = {24'h00_0000, s_reg.adc_off};
        default: s_next.pslverr = 1'b1;
      endcase
    end
    if (commit_wr) begin
      unique case (paddr)
        PAFO_OFF_DIR: s_next.dir = pwdata[7:0];
        PAFO_OFF_LATCH: s_next.latch = pwdata[7:0];
        PAFO_OFF_CTRL: begin
          s_next.gpo = pwdata[PAFO_CTRL_GPO_BIT];
          s_next.pin_change_group0_enable = pwdata[PAFO_CTRL_PIN_CHANGE_GROUP0_ENABLE_BIT];
        end
        PAFO_OFF_MASK: s_next.mask = pwdata[7:0];
        PAFO_OFF_ADCOFF: s_next.adc_off = pwdata[7:0];
        default: s_next.pslverr = 1'b0;
      endcase
    end
    // toggle applies on top of any same-cycle latch write
    s_next.latch = s_next.latch ^ pin_toggle;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_reg.dir <= PAFO_RST_DIR;
      s_reg.latch <= PAFO_RST_LATCH;
      s_reg.mask <= PAFO_RST_MASK;
      s_reg.adc_off <= PAFO_RST_ADCOFF;
      s_reg.gpo <= PAFO_RST_GPO;
      s_reg.pin_change_group0_enable <= PAFO_RST_PIN_CHANGE_GROUP0_ENABLE;
      s_reg.sync1 <= PAFO_RST_PAD;
      s_reg.sync2 <= PAFO_RST_PAD;
      s_reg.in_en <= PAFO_RST_IN_EN;
      s_reg.oe <= PAFO_RST_PAD;
      s_reg.out <= PAFO_RST_PAD;
      s_reg.pull <= PAFO_RST_PAD;
      s_reg.prdata <= PAFO_RST_WORD;
      s_reg.pready <= 1'b0;
      s_reg.pslverr <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign pad_out = s_reg.out;
  assign pad_oe = s_reg.oe;
  assign pad_pullup_en = s_reg.pull;
  // analog pad line n goes ungated to converter channel n, outside this digital block

  // expected values for the checks, built from the rules alone
  logic [PAFO_W-1:0] chk_pull;
  logic [PAFO_W-1:0] chk_out;
  logic [PAFO_W-1:0] chk_toggled;
  logic [PAFO_W-1:0] chk_tgl;
  logic [PAFO_W-1:0] chk_clamped;
  logic [PAFO_W-1:0] chk_adc_off;
  logic [PAFO_W-1:0] chk_gated;
  logic [PAFO_W-1:0] chk_on;
  logic [PAFO_W-1:0] chk_off;
  logic chk_unmapped;

  assign chk_pull = ~s_reg.dir & s_reg.latch & {PAFO_W{~s_reg.gpo}};
  assign chk_out = s_reg.latch & s_reg.dir;
  assign chk_toggled = s_reg.latch ^ pwdata[7:0];
  assign chk_tgl = s_reg.latch ^ toggle_override_enable;
  assign chk_clamped = ~input_enable_override_enable_v & {PAFO_W{sleep_clamp}};
  assign chk_adc_off = s_reg.adc_off & ~input_enable_override_value_v;
  assign chk_gated = pad_in & s_reg.in_en;
  assign chk_on = (input_enable_override_enable_v & input_enable_override_value_v) | (~input_enable_override_enable_v & {PAFO_W{~sleep_clamp}});
  assign chk_off = (input_enable_override_enable_v & ~input_enable_override_value_v) | chk_clamped;
  assign chk_unmapped = !(paddr inside {PAFO_OFF_DIR, PAFO_OFF_LATCH, PAFO_OFF_PIN,
    PAFO_OFF_CTRL, PAFO_OFF_MASK, PAFO_OFF_ADCOFF});

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  property p_pullup;
    1'b1 |=> pad_pullup_en == $past(chk_pull);
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-up enable does not follow direction, latch and global off");

  property p_drive;
    1'b1 |=> pad_oe == $past(s_reg.dir);
  endproperty
  a_drive: assert property (p_drive)
    else $error("output driver enable does not follow direction bits");

  property p_value;
    1'b1 |=> pad_out == $past(chk_out);
  endproperty
  a_value: assert property (p_value)
    else $error("driven pin value does not follow the output latch");

  property p_toggle;
    (commit_wr && paddr == PAFO_OFF_PIN && toggle_override_enable == 8'h00)
      |=> s_reg.latch == $past(chk_toggled);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("pin register write did not toggle the latch");

  property p_in_override;
    1'b1 |=> ((s_reg.in_en ^ $past(input_enable_override_value_v)) & $past(input_enable_override_enable_v)) == 8'h00;
  endproperty
  a_in_override: assert property (p_in_override)
    else $error("overridden input enable differs from override value");

  property p_clamp;
    1'b1 |=> (s_reg.in_en & $past(chk_clamped)) == 8'h00;
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("sleep clamp failed to disable a non-overridden input");

  property p_adc_off;
    1'b1 |=> (s_reg.in_en & $past(chk_adc_off)) == 8'h00;
  endproperty
  a_adc_off: assert property (p_adc_off)
    else $error("analog buffer off did not disable the digital input");

  property p_apb_answer;
    (psel && penable && !pready) |=> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("apb answer not exactly one cycle after access start");

  property p_tap;
    1'b1 |=> (schmitt_input_tap & ~pad_in) == 8'h00
      && ((schmitt_input_tap ^ pad_in) & $past(chk_on)) == 8'h00
      && (schmitt_input_tap & $past(chk_off)) == 8'h00;
  endproperty
  a_tap: assert property (p_tap)
    else $error("schmitt tap not gated by input enable");

  property p_sync;
    1'b1 |=> s_reg.sync1 == $past(chk_gated) && s_reg.sync2 == $past(s_reg.sync1);
  endproperty
  a_sync: assert property (p_sync)
    else $error("pin register is not a two-stage synchroniser of the gated pad");

  property p_in_awake;
    (!sleep_clamp && input_enable_override_enable_v == 8'h00) |=> s_reg.in_en == 8'hFF;
  endproperty
  a_in_awake: assert property (p_in_awake)
    else $error("input enable off while awake and not overridden");

  property p_latch_hold;
    (!commit_wr && toggle_override_enable == 8'h00) |=> $stable(s_reg.latch);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("output latch changed without a write or toggle");

  property p_toggle_pin;
    (!commit_wr && toggle_override_enable != 8'h00) |=> s_reg.latch == $past(chk_tgl);
  endproperty
  a_toggle_pin: assert property (p_toggle_pin)
    else $error("toggle override did not invert the latch bits");

  property p_slverr;
    (psel && penable && !pready && chk_unmapped)
      |=> pready && pslverr && prdata == 32'h0000_0000;
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("unmapped access not answered with an error");

  property p_idle_bus;
    !pready |-> prdata == 32'h0000_0000 && !pslverr;
  endproperty
  a_idle_bus: assert property (p_idle_bus)
    else $error("read data or error shown outside the answer cycle");

  property p_one_answer;
    pready |=> !pready;
  endproperty
  a_one_answer: assert property (p_one_answer)
    else $error("apb answer lasted more than one cycle");

  property p_read_latch;
    (psel && penable && !pready && !pwrite && paddr == PAFO_OFF_LATCH)
      |=> prdata == {24'h00_0000, $past(s_reg.latch)};
  endproperty
  a_read_latch: assert property (p_read_latch)
    else $error("latch read returned wrong data");

  property p_unmapped_write;
    (commit_wr && chk_unmapped)
      |=> $stable(s_reg.dir) && $stable(s_reg.mask) && $stable(s_reg.adc_off)
        && $stable(s_reg.gpo) && $stable(s_reg.pin_change_group0_enable);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write)
    else $error("write to an unmapped address changed a register");

  property p_drive_off;
    1'b1 |-> (pad_out & ~pad_oe) == 8'h00;
  endproperty
  a_drive_off: assert property (p_drive_off)
    else $error("pad value high while its driver is off");

  property p_reset_quiet;
    @(posedge ref_clk) disable iff (1'b0)
      sys_rst |=> pad_oe == 8'h00 && pad_out == 8'h00
        && pad_pullup_en == 8'h00 && schmitt_input_tap == 8'h00;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("pad driver, pull-up or tap active right after reset");

  c_pullup: cover property (pad_pullup_en != 8'h00);
  c_toggle: cover property (commit_wr && paddr == PAFO_OFF_PIN && pwdata[7:0] != 8'h00);
  c_sleep_override: cover property (sleep_clamp && (input_enable_override_enable_v & input_enable_override_value_v) != 8'h00);
  c_unmapped: cover property (pready && pslverr);
  c_adc_off: cover property (chk_adc_off != 8'h00);

endmodule

// ---- test/pafo_periph_model.sv ----
`timescale 1ns/1ps
// peripheral side: pad level source, toggle requests, own tap synchroniser
module pafo_periph_model (
  input wire logic ref_clk,
  input wire logic [7:0] pad_level,
  input wire logic [7:0] toggle_req,
  input wire logic [7:0] schmitt_input_tap,
  output logic [7:0] pad_in,
  output logic [7:0] toggle_override_enable,
  output logic [7:0] tap_sync
);
  logic [7:0] tap_meta;
  assign pad_in = pad_level;
  always_ff @(posedge ref_clk) begin
    tap_meta <= schmitt_input_tap;
    tap_sync <= tap_meta;
    toggle_override_enable <= toggle_req;
  end
endmodule

// ---- test/pafo_port_test.sv ----
`timescale 1ns/1ps
module pafo_port_test;
  import pafo_pkg::*;
  typedef struct packed {
    logic [7:0] dir, lat, ctl, msk, adc;
    logic slp;
    logic [7:0] oe, out, pu, tap;
  } pafo_row_s;
  logic ref_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic sleep_clamp = 1'b0, pready, pslverr;
  logic [7:0] paddr = 8'h00, pad_level = 8'hFF, toggle_req = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] pad_in, pad_out, pad_oe, pad_pullup_en, tap, tgl, tap_sync;
  logic err;
  int fails = 0, n_checks = 0;
  pafo_row_s rows [4] = '{
    '{8'hF0, 8'hCC, 8'h00, 8'h00, 8'h00, 1'b0, 8'hF0, 8'hC0, 8'h0C, 8'hFF},
    '{8'h0F, 8'hAA, 8'h03, 8'h0F, 8'h30, 1'b1, 8'h0F, 8'h0A, 8'h00, 8'h0F},
    '{8'h00, 8'hFF, 8'h02, 8'hF0, 8'h01, 1'b0, 8'h00, 8'h00, 8'hFF, 8'hFE},
    '{8'hFF, 8'h55, 8'h00, 8'hFF, 8'h00, 1'b1, 8'hFF, 8'h55, 8'h00, 8'h00}};
  always #12.5 ref_clk = ~ref_clk;
  pafo_port u_pafo_port (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en), .schmitt_input_tap(tap),
    .sleep_clamp(sleep_clamp), .toggle_override_enable(tgl));
  pafo_periph_model u_pafo_periph_model (.ref_clk(ref_clk), .pad_level(pad_level),
    .toggle_req(toggle_req), .schmitt_input_tap(tap), .pad_in(pad_in),
    .toggle_override_enable(tgl), .tap_sync(tap_sync));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      $display("MISMATCH %0t no ready", $time);
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle();
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1;
    chk(32'({pad_oe, pad_out, pad_pullup_en, tap}), 32'h0);
    for (int a = 0; a < 6; a++) begin
      apb(1'b0, 8'(a * 4), 32'h0);
      chk(rd, (8'(a * 4) == PAFO_OFF_PIN) ? 32'(pad_level) : PAFO_RST_WORD);
    end
    foreach (rows[i]) begin
      apb(1'b1, PAFO_OFF_DIR, 32'(rows[i].dir));
      apb(1'b1, PAFO_OFF_LATCH, 32'(rows[i].lat));
      apb(1'b1, PAFO_OFF_CTRL, 32'(rows[i].ctl));
      apb(1'b1, PAFO_OFF_MASK, 32'(rows[i].msk));
      apb(1'b1, PAFO_OFF_ADCOFF, 32'(rows[i].adc));
      sleep_clamp <= rows[i].slp;
      settle();
      chk(32'(pad_oe), 32'(rows[i].oe));
      chk(32'(pad_out), 32'(rows[i].out));
      chk(32'(pad_pullup_en), 32'(rows[i].pu));
      chk(32'(tap), 32'(rows[i].tap));
      apb(1'b0, PAFO_OFF_LATCH, 32'h0);
      chk(rd, 32'(rows[i].lat));
    end
    apb(1'b0, 8'h18, 32'h0);
    chk(32'({err, rd[30:0]}), 32'h8000_0000);
    apb(1'b1, 8'h18, 32'hFF);
    chk(32'(err), 32'h1);
    apb(1'b0, PAFO_OFF_DIR, 32'h0);
    chk(rd, 32'hFF);
    apb(1'b1, PAFO_OFF_PIN, 32'h0F);
    apb(1'b0, PAFO_OFF_LATCH, 32'h0);
    chk(rd, 32'h5A);
    @(posedge ref_clk);
    toggle_req <= 8'hF0;
    @(posedge ref_clk);
    toggle_req <= 8'h00;
    apb(1'b0, PAFO_OFF_LATCH, 32'h0);
    chk(rd, 32'hAA);
    settle();
    chk(32'(pad_out), 32'hAA);
    apb(1'b1, PAFO_OFF_MASK, 32'h0);
    sleep_clamp <= 1'b0;
    pad_level <= 8'h3C;
    settle();
    chk(32'(tap), 32'h3C);
    chk(32'(tap_sync), 32'h3C);
    apb(1'b0, PAFO_OFF_PIN, 32'h0);
    chk(rd, 32'h3C);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1;
    chk(32'({pad_oe, pad_out, pad_pullup_en, tap}), 32'h0);
    apb(1'b0, PAFO_OFF_LATCH, 32'h0);
    chk(rd, 32'(PAFO_RST_LATCH));
    complete_run();
  end
endmodule
